// file: hdl/sah_msg_handler.sv
/*
 Binary message handler: parses host queries and ephemeris uploads from a
 byte stream, emits visible-satellite, almanac status, almanac page and
 ephemeris echo frames. Assumes a same-clock byte stream on both sides,
 a one-cycle epochTick each second, a visibility list sorted by falling
 elevation, and an almanac store read combinationally.
*/
`timescale 1ns/1ps
`include "sah_params.svh"
module sah_msg_handler (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Host byte stream
	input wire logic rxValid,
	input wire logic [7:0] rxByte,
	output logic txValid,
	output logic [7:0] txByte,
	input wire logic txReady,
	// Epoch
	input wire logic epochTick,
	// Visibility engine
	input wire logic [5:0] visTotal,
	input sah_pkg::sahSlot_t [11:0] visList,
	input wire logic visChanged,
	// Almanac store
	input sah_pkg::sahAlmStat_t almStat,
	input wire logic almChanged,
	output logic [5:0] almRdPage,
	output logic [4:0] almRdByte,
	input wire logic [7:0] almRdData,
	// Ephemeris store
	output logic [`SAH_EPH_SATS-1:0] ephUsable,
	input wire logic [5:0] ephRdSat,
	input wire logic [6:0] ephRdIdx,
	output logic [7:0] ephRdData
);
	import sah_pkg::*;

	sahRxState_t rxState_q;
	sahKind_t rxKind_q, txKind_q;
	logic [6:0] rxCnt_q, txIdx_q, txLen, pay;
	logic [7:0] rxSum_q, txSum_q, nextByte, txByte_q;
	// Mode byte apart from the upload buffer, so queries cannot spoil an echo
	logic [7:0] modeByte_q;
	logic [7:0] rxBuf [0:72];
	logic [7:0] ephMem [0:`SAH_EPH_SATS*`SAH_EPH_BYTES-1];
	logic [31:0] ephRef_q [0:`SAH_EPH_SATS-1];
	logic [`SAH_EPH_SATS-1:0] ephLoaded_q;
	logic [31:0] secNow_q;
	logic cmdGo, txValid_q, advance, lastByte, startAny;
	logic visCont_q, statCont_q, dumpCont_q;
	logic visPend_q, statPend_q, echoPend_q, dumpPend_q, dumpEmpty_q;
	logic [5:0] pageIdx_q;
	logic [10:0] epochBytes_q;
	logic [3:0] visCnt_q, slotCnt_q;
	logic [2:0] fldCnt_q;
	logic [11:0] ephAddr;
	sahKind_t startKind;

	// Subframe and page of dump position k
	function automatic logic [15:0] sahPageOf(input logic [5:0] k);
		if (k < 6'd25)
			sahPageOf = {8'h05, 2'b00, k + 6'd1};
		else if (k < 6'd29)
			sahPageOf = {8'h04, 2'b00, k - 6'd23};
		else if (k < 6'd33)
			sahPageOf = {8'h04, 2'b00, k - 6'd22};
		else
			sahPageOf = {8'h04, 8'h19};
	endfunction : sahPageOf

	// Payload length of a received frame kind
	function automatic logic [6:0] sahRxPay(input sahKind_t k);
		sahRxPay = (k == FK_UPL) ? `SAH_UPL_PAY : 7'd1;
	endfunction : sahRxPay

	// (RULE2) validated close of frame
	assign cmdGo = rxValid && rxState_q == RX_LF && rxByte == `SAH_LF && rxSum_q == 8'h00 &&
		(rxKind_q != FK_UPL || (rxBuf[0] != 8'h00 && rxBuf[0] <= `SAH_SATELLITE_IDENTIFIER_MAX));

	// (RULE1) receive framing
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rxState_q <= RX_SYNC1;
			rxKind_q <= FK_NONE;
			rxCnt_q <= 7'h00;
			rxSum_q <= 8'h00;
		end
		else if (rxValid)
		begin
			case (rxState_q)
				RX_SYNC1: rxState_q <= (rxByte == `SAH_SYNC) ? RX_SYNC2 : RX_SYNC1;
				RX_SYNC2: rxState_q <= (rxByte == `SAH_SYNC) ? RX_ID1 : RX_SYNC1;
				RX_ID1:
				begin
					rxSum_q <= rxByte;
					rxState_q <= (rxByte == `SAH_ID_B) ? RX_ID2 : RX_SYNC1;
				end
				RX_ID2:
				begin
					rxSum_q <= rxSum_q ^ rxByte;
					rxCnt_q <= 7'h00;
					rxState_q <= RX_BODY;
					case (rxByte)
						`SAH_ID_VIS: rxKind_q <= FK_VIS;
						`SAH_ID_STAT: rxKind_q <= FK_STAT;
						`SAH_ID_DUMP: rxKind_q <= FK_DUMP;
						`SAH_ID_UPL: rxKind_q <= FK_UPL;
						default: rxState_q <= RX_SYNC1;
					endcase
					// Echo buffer busy: a second upload is dropped
					if (rxByte == `SAH_ID_UPL && echoPend_q)
						rxState_q <= RX_SYNC1;
				end
				RX_BODY:
				begin
					rxSum_q <= rxSum_q ^ rxByte;
					rxCnt_q <= rxCnt_q + 7'd1;
					if (rxCnt_q == sahRxPay(rxKind_q) - 7'd1)
						rxState_q <= RX_CKS;
				end
				RX_CKS:
				begin
					rxSum_q <= rxSum_q ^ rxByte;
					rxState_q <= RX_CR;
				end
				RX_CR: rxState_q <= (rxByte == `SAH_CR) ? RX_LF : RX_SYNC1;
				RX_LF: rxState_q <= RX_SYNC1;
				default: rxState_q <= RX_SYNC1;
			endcase
		end
	end

	// (RULE20) payload capture
	always_ff @(posedge clk)
	begin
		if (rxValid && rxState_q == RX_BODY && rxKind_q == FK_UPL && !echoPend_q)
			rxBuf[rxCnt_q] <= rxByte;
		if (rxValid && rxState_q == RX_BODY && rxCnt_q == 7'h00)
			modeByte_q <= rxByte;
	end

	// (RULE3) (RULE9) (RULE14) mode latching
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			visCont_q <= 1'b0;
			statCont_q <= 1'b0;
			dumpCont_q <= 1'b0;
		end
		else if (cmdGo)
		begin
			if (rxKind_q == FK_VIS)
				visCont_q <= modeByte_q[0];
			if (rxKind_q == FK_STAT)
				statCont_q <= modeByte_q[0];
			if (rxKind_q == FK_DUMP)
				dumpCont_q <= modeByte_q[0];
		end
	end

	assign advance = txKind_q != FK_NONE && (!txValid_q || txReady);
	assign lastByte = advance && txIdx_q == txLen - 7'd1;
	assign pay = txIdx_q - 7'd4;

	// Frame priority: echo, status, visibility, then budgeted pages
	always_comb
	begin
		startKind = FK_NONE;
		if (echoPend_q)
			startKind = FK_ECHO;
		else if (statPend_q)
			startKind = FK_STAT;
		else if (visPend_q)
			startKind = FK_VIS;
		// (RULE17) epoch byte budget
		else if (dumpPend_q && epochBytes_q <= `SAH_BUDGET)
			startKind = FK_PAGE;
	end
	assign startAny = txKind_q == FK_NONE && startKind != FK_NONE;

	// Pending flags; a new event in the start cycle is kept
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			visPend_q <= 1'b0;
			statPend_q <= 1'b0;
			echoPend_q <= 1'b0;
		end
		else
		begin
			if (startAny && startKind == FK_VIS)
				visPend_q <= 1'b0;
			if (startAny && startKind == FK_STAT)
				statPend_q <= 1'b0;
			if (lastByte && txKind_q == FK_ECHO)
				echoPend_q <= 1'b0;
			// (RULE3) visibility replies
			if ((cmdGo && rxKind_q == FK_VIS) || (visCont_q && visChanged))
				visPend_q <= 1'b1;
			// (RULE9) status replies
			if ((cmdGo && rxKind_q == FK_STAT) || (statCont_q && almChanged))
				statPend_q <= 1'b1;
			// (RULE21) echo after valid upload
			if (cmdGo && rxKind_q == FK_UPL)
				echoPend_q <= 1'b1;
		end
	end

	// (RULE15) (RULE18) dump walk
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dumpPend_q <= 1'b0;
			dumpEmpty_q <= 1'b0;
			pageIdx_q <= 6'h00;
		end
		else
		begin
			if (lastByte && txKind_q == FK_PAGE)
			begin
				if (dumpEmpty_q || pageIdx_q == `SAH_PAGES_LAST)
					dumpPend_q <= 1'b0;
				else
					pageIdx_q <= pageIdx_q + 6'd1;
			end
			// (RULE14) restart wins over completion
			if ((cmdGo && rxKind_q == FK_DUMP) || (dumpCont_q && almChanged))
			begin
				dumpPend_q <= 1'b1;
				pageIdx_q <= 6'h00;
				dumpEmpty_q <= !almStat.valid;
			end
		end
	end

	// (RULE17) per-epoch byte count
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			epochBytes_q <= 11'h000;
		else if (epochTick)
			epochBytes_q <= {10'h000, advance};
		else if (advance && epochBytes_q != 11'h7ff)
			epochBytes_q <= epochBytes_q + 11'd1;
	end

	always_comb
	begin
		case (txKind_q)
			FK_VIS: txLen = `SAH_LEN_VIS;
			FK_STAT: txLen = `SAH_LEN_STAT;
			FK_PAGE: txLen = `SAH_LEN_PAGE;
			FK_ECHO: txLen = `SAH_LEN_ECHO;
			default: txLen = 7'd1;
		endcase
	end

	assign almRdPage = pageIdx_q;
	assign almRdByte = 5'(pay - 7'd2);

	// Byte at the current frame position
	always_comb
	begin
		logic [15:0] sp;
		logic [55:0] slot;
		sp = dumpEmpty_q ? 16'h0000 : sahPageOf(pageIdx_q);
		slot = (slotCnt_q < `SAH_SLOTS) ? visList[slotCnt_q] : 56'h0;
		nextByte = 8'h00;
		// (RULE1) header and trailer
		if (txIdx_q < 7'd2)
			nextByte = `SAH_SYNC;
		else if (txIdx_q == 7'd2)
			nextByte = (txKind_q == FK_VIS || txKind_q == FK_STAT) ? `SAH_ID_B : `SAH_ID_C;
		else if (txIdx_q == 7'd3)
		begin
			case (txKind_q)
				FK_VIS: nextByte = `SAH_ID_VIS;
				FK_STAT: nextByte = `SAH_ID_STAT;
				FK_PAGE: nextByte = `SAH_ID_PAGE;
				default: nextByte = `SAH_ID_ECHO;
			endcase
		end
		// (RULE2) checksum byte
		else if (txIdx_q == txLen - 7'd3)
			nextByte = txSum_q;
		else if (txIdx_q == txLen - 7'd2)
			nextByte = `SAH_CR;
		else if (txIdx_q == txLen - 7'd1)
			nextByte = `SAH_LF;
		else
		begin
			case (txKind_q)
				FK_VIS:
				begin
					// (RULE4) count then zero-filled slots
					if (pay == 7'd0)
						nextByte = {4'h0, visCnt_q};
					else if (slotCnt_q < visCnt_q)
					begin
						// (RULE6) (RULE7) slot fields, high byte first
						case (fldCnt_q)
							3'd0: nextByte = slot[55:48];
							3'd1: nextByte = slot[47:40];
							3'd2: nextByte = slot[39:32];
							3'd3: nextByte = slot[31:24];
							3'd4: nextByte = slot[23:16];
							3'd5: nextByte = slot[15:8];
							default: nextByte = slot[7:0];
						endcase
					end
				end
				FK_STAT:
				begin
					// (RULE10) (RULE11) (RULE12) (RULE13) status layout
					case (pay)
						7'd0: nextByte = {7'h00, almStat.valid};
						7'd1: nextByte = almStat.week;
						7'd2: nextByte = almStat.toa;
						7'd3: nextByte = almStat.count;
						7'd4: nextByte = almStat.mask[31:24];
						7'd5: nextByte = almStat.mask[23:16];
						7'd6: nextByte = almStat.mask[15:8];
						7'd7: nextByte = almStat.mask[7:0];
						default: nextByte = 8'h00;
					endcase
				end
				FK_PAGE:
				begin
					// (RULE16) (RULE18) page layout
					if (pay == 7'd0)
						nextByte = sp[15:8];
					else if (pay == 7'd1)
						nextByte = sp[7:0];
					else
						nextByte = dumpEmpty_q ? 8'h00 : almRdData;
				end
				FK_ECHO: nextByte = rxBuf[pay];
				default: nextByte = 8'h00;
			endcase
		end
	end

	// (RULE8) transmit sequencing
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			txKind_q <= FK_NONE;
			txIdx_q <= 7'h00;
			txSum_q <= 8'h00;
			txValid_q <= 1'b0;
			txByte_q <= 8'h00;
			slotCnt_q <= 4'h0;
			fldCnt_q <= 3'h0;
			visCnt_q <= 4'h0;
		end
		else
		begin
			if (advance)
			begin
				txByte_q <= nextByte;
				txValid_q <= 1'b1;
				txIdx_q <= txIdx_q + 7'd1;
				if (txIdx_q == 7'd2)
					txSum_q <= nextByte;
				else if (txIdx_q < txLen - 7'd3)
					txSum_q <= txSum_q ^ nextByte;
				if (txKind_q == FK_VIS && txIdx_q > 7'd4)
				begin
					fldCnt_q <= (fldCnt_q == `SAH_SLOT_LAST) ? 3'h0 : fldCnt_q + 3'd1;
					if (fldCnt_q == `SAH_SLOT_LAST)
						slotCnt_q <= slotCnt_q + 4'd1;
				end
				if (lastByte)
					txKind_q <= FK_NONE;
			end
			else if (txReady)
				txValid_q <= 1'b0;
			if (startAny)
			begin
				txKind_q <= startKind;
				txIdx_q <= 7'h00;
				slotCnt_q <= 4'h0;
				fldCnt_q <= 3'h0;
				// (RULE5) first twelve of the elevation-sorted list
				visCnt_q <= (visTotal > 6'd12) ? `SAH_SLOTS : visTotal[3:0];
			end
		end
	end
	assign txValid = txValid_q;
	assign txByte = txByte_q;

	// (RULE22) seconds since reset, for ephemeris age
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			secNow_q <= 32'h0;
		else if (epochTick)
			secNow_q <= secNow_q + 32'd1;
	end

	assign ephAddr = 12'((rxBuf[0] - 8'd1) * `SAH_EPH_BYTES + (pay - 7'd1));

	// (RULE21) commit ephemeris as the echo goes out
	always_ff @(posedge clk)
	begin
		if (advance && txKind_q == FK_ECHO && pay >= 7'd1 && pay <= 7'd72 && txIdx_q >= 7'd4)
			ephMem[ephAddr] <= nextByte;
		ephRdData <= ephMem[12'(ephRdSat * `SAH_EPH_BYTES + ephRdIdx)];
	end

	genvar g;
	generate
		for (g = 0; g < `SAH_EPH_SATS; g++)
		begin : gEph
			// (RULE22) age stamp and usability
			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					ephLoaded_q[g] <= 1'b0;
					ephRef_q[g] <= 32'h0;
				end
				else if (startAny && startKind == FK_ECHO && rxBuf[0] == 8'(g + 1))
				begin
					ephLoaded_q[g] <= 1'b1;
					ephRef_q[g] <= secNow_q;
				end
			end
			assign ephUsable[g] = ephLoaded_q[g] && (secNow_q - ephRef_q[g]) < `SAH_EPH_AGE_SEC;
		end
	endgenerate

	sequence seqFrameOpen;
		advance && txIdx_q == 7'd0;
	endsequence
	sequence seqFrameClose;
		advance && txIdx_q == txLen - 7'd1;
	endsequence

	AST_SYNC_PAIR: assert property (@(posedge clk) disable iff (!arst_n) // RULE1
		seqFrameOpen |=> txByte_q == `SAH_SYNC ##1 (!txValid_q || txByte_q == `SAH_SYNC))
		else $error("frame does not open with two sync bytes");
	AST_LINE_END: assert property (@(posedge clk) disable iff (!arst_n) // RULE1
		seqFrameClose |=> txByte_q == `SAH_LF && txKind_q == FK_NONE)
		else $error("frame does not end with line feed");
	AST_CHECKSUM: assert property (@(posedge clk) disable iff (!arst_n) // RULE2
		advance && txIdx_q == txLen - 7'd3 |=> txByte_q == $past(txSum_q))
		else $error("checksum byte differs from running xor");
	AST_VIS_COUNT: assert property (@(posedge clk) disable iff (!arst_n) // RULE5
		startAny && startKind == FK_VIS |=> visCnt_q <= `SAH_SLOTS &&
		(visCnt_q == `SAH_SLOTS || 6'(visCnt_q) == $past(visTotal)))
		else $error("visible count not the total capped at twelve");
	AST_ZERO_SLOT: assert property (@(posedge clk) disable iff (!arst_n) // RULE4
		advance && txKind_q == FK_VIS && pay > 7'd0 && slotCnt_q >= visCnt_q &&
		txIdx_q < txLen - 7'd3 |=> txByte_q == 8'h00)
		else $error("unused slot byte not zero");
	AST_BUDGET: assert property (@(posedge clk) disable iff (!arst_n) // RULE17
		txKind_q == FK_PAGE && $changed(txKind_q) |-> $past(epochBytes_q) <= `SAH_BUDGET)
		else $error("page started over epoch budget");
	AST_EMPTY_ONE: assert property (@(posedge clk) disable iff (!arst_n) // RULE18
		seqFrameClose and txKind_q == FK_PAGE && dumpEmpty_q && !almChanged && !cmdGo
		|=> !dumpPend_q)
		else $error("empty dump sent more than one page");
	AST_ECHO_PEND: assert property (@(posedge clk) disable iff (!arst_n) // RULE21
		cmdGo && rxKind_q == FK_UPL |=> echoPend_q ##[1:1000] txKind_q == FK_ECHO)
		else $error("valid upload not echoed");
	AST_VIS_MODE: assert property (@(posedge clk) disable iff (!arst_n) // RULE3
		cmdGo && rxKind_q == FK_VIS |=> visPend_q && visCont_q == $past(modeByte_q[0]))
		else $error("visible mode not taken");
endmodule : sah_msg_handler

// file: hdl/sah_params.svh
/*
 Constants of the satellite almanac message handler: framing bytes,
 identifiers, frame lengths and limits. Assumes inclusion by bare name.
*/
// How it works
// (RULE1) Frames start with two 0x40 bytes, an identifier, payload, checksum, CR LF.
// (RULE2) Checksum is XOR of identifier and payload; bad frames are dropped.
// (RULE3) Visible query is 8 bytes; mode 0 polls once, mode 1 replies on change.
// (RULE4) Visible reply has count 0..12, then twelve slots; unused slots all zero.
// (RULE5) Above twelve visible, only the twelve highest by elevation are reported.
// (RULE6) Slot: identifier, signed Doppler, elevation, two-byte azimuth, health.
// (RULE7) Health byte is 0 for healthy, 1 for unhealthy and removed.
// (RULE8) Visible reply is exactly 92 bytes with no separators.
// (RULE9) Status query is 8 bytes; mode 0 once, mode 1 on almanac change.
// (RULE10) Status reply starts with validity byte, 0 none, 1 valid almanac.
// (RULE11) Then raw week, raw time of almanac, available satellite count 0..32.
// (RULE12) 32-bit presence mask; bit n-1 stands for satellite n.
// (RULE13) Eight reserved bytes close the status reply; 23 bytes in total.
// (RULE14) Dump query is 8 bytes; mode 0 dumps once, mode 1 on every change.
// (RULE15) Full dump is 34 pages: sf5 pages 1..25, then sf4 2..5, 7..10, 25.
// (RULE16) Page frame is 33 bytes: subframe/page then eight 3-byte words.
// (RULE17) No new page once epoch byte total exceeds 750; resume next epoch.
// (RULE18) Dump without almanac sends one page frame with all bytes zero.
// (RULE19) Host sends ephemeris uploads on the first serial port.
// (RULE20) Upload is 80 bytes: identifier 1..37 and 72 bytes of words.
// (RULE21) A valid upload is echoed back as an 80-byte echo frame.
// (RULE22) Ephemeris kept while powered, usable only under four hours old.
`ifndef SAH_PARAMS_SVH
`define SAH_PARAMS_SVH
`define SAH_SYNC 8'h40
`define SAH_CR 8'h0d
`define SAH_LF 8'h0a
`define SAH_ID_B 8'h42
`define SAH_ID_C 8'h43
`define SAH_ID_VIS 8'h62
`define SAH_ID_STAT 8'h64
`define SAH_ID_DUMP 8'h65
`define SAH_ID_UPL 8'h66
`define SAH_ID_PAGE 8'h62
`define SAH_ID_ECHO 8'h63
`define SAH_LEN_VIS 7'd92
`define SAH_LEN_STAT 7'd23
`define SAH_LEN_PAGE 7'd33
`define SAH_LEN_ECHO 7'd80
`define SAH_UPL_PAY 7'd73
`define SAH_SLOTS 4'd12
`define SAH_SLOT_LAST 3'd6
`define SAH_PAGES_LAST 6'd33
`define SAH_BUDGET 11'd750
`define SAH_EPH_SATS 37
`define SAH_EPH_BYTES 72
`define SAH_SATELLITE_IDENTIFIER_MAX 8'h25
`define SAH_EPH_AGE_SEC 32'd14400
`endif

// file: hdl/sah_pkg.sv
/*
 Types of the satellite almanac message handler.
 Assumes sah_params.svh for the numeric constants.
*/
package sah_pkg;
	typedef struct packed {
		logic [7:0] satId;
		logic [15:0] doppler;
		logic [7:0] elev;
		logic [15:0] azimuth;
		logic [7:0] health;
	} sahSlot_t;
	typedef struct packed {
		logic valid;
		logic [7:0] week;
		logic [7:0] toa;
		logic [7:0] count;
		logic [31:0] mask;
	} sahAlmStat_t;
	typedef enum logic [2:0] {
		FK_NONE = 3'b000, FK_VIS = 3'b001, FK_STAT = 3'b010, FK_DUMP = 3'b011,
		FK_UPL = 3'b100, FK_PAGE = 3'b101, FK_ECHO = 3'b110
	} sahKind_t;
	typedef enum logic [2:0] {
		RX_SYNC1 = 3'b000, RX_SYNC2 = 3'b001, RX_ID1 = 3'b010, RX_ID2 = 3'b011,
		RX_BODY = 3'b100, RX_CKS = 3'b101, RX_CR = 3'b110, RX_LF = 3'b111
	} sahRxState_t;
endpackage : sah_pkg

// file: verif/sah_host_model.sv
/*
 Host model on the serial byte stream: sends framed queries and uploads,
 collects every accepted reply byte. Assumes same-clock byte streams.
*/
`timescale 1ns/1ps
`include "sah_params.svh"
module sah_host_model (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Host to device
	output logic rxValid,
	output logic [7:0] rxByte,
	// Device to host
	input wire logic txValid,
	input wire logic [7:0] txByte,
	output logic txReady
);
	logic [7:0] got[$];
	logic stall;

	initial
	begin
		rxValid = 1'b0;
		rxByte = 8'h00;
		txReady = 1'b1;
		stall = 1'b0;
	end

	// Stalling toggles ready so replies crawl
	always @(posedge clk)
	begin
		if (arst_n && txValid && txReady)
			got.push_back(txByte);
		#1;
		txReady = stall ? ~txReady : 1'b1;
	end

	task automatic send(input logic [7:0] id2, input logic [7:0] pay[$], input logic badCks);
		logic [7:0] f[$];
		logic [7:0] c;
		c = `SAH_ID_B ^ id2;
		foreach (pay[i]) c ^= pay[i];
		f = {`SAH_SYNC, `SAH_SYNC, `SAH_ID_B, id2};
		f = {f, pay};
		f.push_back(badCks ? ~c : c);
		f.push_back(`SAH_CR);
		f.push_back(`SAH_LF);
		foreach (f[i])
		begin
			@(posedge clk);
			#1;
			rxValid = 1'b1;
			rxByte = f[i];
		end
		@(posedge clk);
		#1;
		rxValid = 1'b0;
		// Released line shows no stale byte
		rxByte = ~rxByte;
	endtask : send
endmodule : sah_host_model

// file: verif/sah_msg_handler_tb.sv
/*
 Self-checking bench of the message handler with a host model.
 Assumes the handler's byte-stream contract and a sorted visibility list.
*/
`timescale 1ns/1ps
`include "sah_params.svh"
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin errTotal++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module sah_msg_handler_tb;
	import sah_pkg::*;
	logic clk, arst_n, rxValid, txValid, txReady, epochTick, visChanged, almChanged;
	logic [7:0] rxByte, txByte, almRdData, ephRdData;
	logic [5:0] visTotal, almRdPage, ephRdSat;
	logic [4:0] almRdByte;
	logic [6:0] ephRdIdx;
	logic [`SAH_EPH_SATS-1:0] ephUsable;
	sahSlot_t [11:0] visList;
	sahAlmStat_t almStat;
	int errTotal, nTests;
	logic [7:0] fr[$];

	// Store content tagged by page and byte
	assign almRdData = {almRdPage[2:0], almRdByte};

	sah_msg_handler sah_msg_handler_i (.clk(clk), .arst_n(arst_n), .rxValid(rxValid),
		.rxByte(rxByte), .txValid(txValid), .txByte(txByte), .txReady(txReady),
		.epochTick(epochTick), .visTotal(visTotal), .visList(visList),
		.visChanged(visChanged), .almStat(almStat), .almChanged(almChanged),
		.almRdPage(almRdPage), .almRdByte(almRdByte), .almRdData(almRdData),
		.ephUsable(ephUsable), .ephRdSat(ephRdSat), .ephRdIdx(ephRdIdx),
		.ephRdData(ephRdData));
	sah_host_model sah_host_model_i (.clk(clk), .arst_n(arst_n), .rxValid(rxValid),
		.rxByte(rxByte), .txValid(txValid), .txByte(txByte), .txReady(txReady));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", nTests, errTotal);
		if (errTotal == 0 && nTests > 0)
		begin
			$display("Regression OK");
		end
		else
		begin
			$display("Regression broken");
		end
		$finish;
	endtask : complete_run

	task automatic pulse(ref logic s);
		@(posedge clk);
		#1 s = 1'b1;
		@(posedge clk);
		#1 s = 1'b0;
	endtask : pulse

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : idle

	// Mode 1 request; whatever it answers at once is dropped
	task automatic arm(input logic [7:0] id2);
		sah_host_model_i.send(id2, {8'h01}, 1'b0);
		idle(400);
		sah_host_model_i.got = {};
	endtask : arm

	task automatic get_frame(input int len, input logic [7:0] id1, input logic [7:0] id2);
		int w;
		logic [7:0] c;
		w = 0;
		while (sah_host_model_i.got.size() < len && w < 3000)
		begin
			@(posedge clk);
			#1;
			w++;
		end
		fr = {};
		repeat (len) fr.push_back(sah_host_model_i.got.size() > 0 ?
			sah_host_model_i.got.pop_front() : 8'hxx);
		`CHK("sync", 16'h4040, {fr[0], fr[1]})
		`CHK("ident", {id1, id2}, {fr[2], fr[3]})
		`CHK("trailer", 16'h0d0a, {fr[len-2], fr[len-1]})
		c = 8'h00;
		for (int k = 2; k < len - 3; k++) c ^= fr[k];
		`CHK("checksum", c, fr[len-3])
	endtask : get_frame

	task automatic t_vis;
		logic [55:0] g;
		int n;
		for (int i = 0; i < 12; i++)
		begin
			visList[i].satId = 8'(i + 1);
			visList[i].doppler = 16'(i * 900 - 5000);
			visList[i].elev = 8'(90 - i * 7);
			visList[i].azimuth = 16'(i * 30 + 7);
			visList[i].health = {7'h00, i[0]};
		end
		for (int m = 0; m < 2; m++)
		begin
			visTotal = (m == 0) ? 6'd14 : 6'd3;
			if (m == 0)
				sah_host_model_i.send(`SAH_ID_VIS, {8'h00}, 1'b0);
			else
			begin
				arm(`SAH_ID_VIS);
				pulse(visChanged);
			end
			get_frame(92, `SAH_ID_B, `SAH_ID_VIS);
			n = (m == 0) ? 12 : 3;
			`CHK("vis count", 8'(n), fr[4])
			for (int s = 0; s < 12; s++)
			begin
				g = '0;
				for (int k = 0; k < 7; k++) g = {g[47:0], fr[5 + 7 * s + k]};
				`CHK("vis slot", (s < n) ? 56'(visList[s]) : 56'h0, g)
			end
		end
	endtask : t_vis

	task automatic t_dump;
		int bad;
		logic [7:0] sf, pg;
		logic [7:0] sf4[9] = '{2, 3, 4, 5, 7, 8, 9, 10, 25};
		almStat = '{1'b1, 8'h5a, 8'h93, 8'h20, 32'h8000_0001};
		pulse(epochTick);
		sah_host_model_i.send(`SAH_ID_DUMP, {8'h00}, 1'b0);
		idle(1200);
		`CHK("epoch bytes", 759, sah_host_model_i.got.size())
		pulse(epochTick);
		for (int p = 0; p < 34; p++)
		begin
			get_frame(33, `SAH_ID_C, `SAH_ID_PAGE);
			sf = (p < 25) ? 8'h05 : 8'h04;
			pg = (p < 25) ? 8'(p + 1) : sf4[p - 25];
			`CHK("subframe page", {sf, pg}, {fr[4], fr[5]})
			bad = 0;
			for (int k = 0; k < 24; k++)
				if (fr[6 + k] !== {3'(p), 5'(k)})
					bad++;
			`CHK("page data", 0, bad)
		end
		idle(200);
		`CHK("dump end", 0, sah_host_model_i.got.size())
	endtask : t_dump

	task automatic t_status;
		logic [63:0] g;
		for (int m = 0; m < 2; m++)
		begin
			if (m == 0)
				sah_host_model_i.send(`SAH_ID_STAT, {8'h00}, 1'b0);
			else
			begin
				arm(`SAH_ID_STAT);
				almStat = '0;
				// Empty store, dump armed too
				arm(`SAH_ID_DUMP);
				pulse(almChanged);
			end
			get_frame(23, `SAH_ID_B, `SAH_ID_STAT);
			g = '0;
			for (int k = 4; k < 12; k++) g = {g[55:0], fr[k]};
			`CHK("status", {7'h00, almStat}, g)
		end
		get_frame(33, `SAH_ID_C, `SAH_ID_PAGE);
		g = '0;
		for (int k = 4; k < 30; k++) g[7:0] = g[7:0] | fr[k];
		`CHK("empty page", 8'h00, g[7:0])
		idle(200);
		`CHK("one empty page", 0, sah_host_model_i.got.size())
	endtask : t_status

	task automatic t_upload;
		logic [7:0] pay[$];
		int bad;
		pay = {8'h25};
		for (int k = 0; k < 72; k++) pay.push_back(8'(k * 7 + 3));
		sah_host_model_i.stall = 1'b1;
		sah_host_model_i.send(`SAH_ID_UPL, pay, 1'b0);
		get_frame(80, `SAH_ID_C, `SAH_ID_ECHO);
		sah_host_model_i.stall = 1'b0;
		bad = 0;
		for (int k = 0; k < 73; k++)
			if (fr[4 + k] !== pay[k])
				bad++;
		`CHK("echo body", 0, bad)
		`CHK("usable", 1'b1, ephUsable[36])
		@(posedge clk);
		#1 ephRdSat = 6'd36;
		ephRdIdx = 7'd10;
		@(posedge clk);
		#1 `CHK("eph read", pay[11], ephRdData)
		// Refusals: bad checksum, identifier past the top
		sah_host_model_i.send(`SAH_ID_VIS, {8'h00}, 1'b1);
		pay[0] = 8'h06;
		sah_host_model_i.send(`SAH_ID_UPL, pay, 1'b1);
		pay[0] = 8'h26;
		sah_host_model_i.send(`SAH_ID_UPL, pay, 1'b0);
		idle(400);
		`CHK("refused", 0, sah_host_model_i.got.size())
		`CHK("not stored", 1'b0, ephUsable[5])
	endtask : t_upload

	initial
	begin
		errTotal = 0;
		nTests = 0;
		arst_n = 1'b0;
		epochTick = 1'b0;
		visChanged = 1'b0;
		almChanged = 1'b0;
		visTotal = 6'd0;
		visList = '0;
		almStat = '0;
		ephRdSat = 6'd0;
		ephRdIdx = 7'd0;
		repeat (3) @(posedge clk);
		`CHK("reset tx", 1'b0, txValid)
		`CHK("reset eph", 37'h0, ephUsable)
		#1 arst_n = 1'b1;
		t_vis();
		t_dump();
		t_status();
		t_upload();
		complete_run();
	end

	// Whole sequence needs well under 15000 cycles
	initial
	begin
		repeat (30000) @(posedge clk);
		errTotal++;
		complete_run();
	end
endmodule : sah_msg_handler_tb
